/* tx_driver_control_params.svh */
// offsets, field positions and reset values of the transmit driver control bytes
// assumes byte-wide registers numbered as the management host addresses them
`ifndef TX_DRIVER_CONTROL_PARAMS_SVH
`define TX_DRIVER_CONTROL_PARAMS_SVH

`define TXC_ADDR_SHAPE 8'h0d
`define TXC_ADDR_CROSS 8'h0e
`define TXC_ADDR_BIAS_HIGH 8'h0f
`define TXC_ADDR_MON_SEL 8'h10
`define TXC_ADDR_BIAS_THR 8'h11
`define TXC_ADDR_POWER_THR 8'h12

`define TXC_NUM_REGS 6
`define TXC_IDX_SHAPE 0
`define TXC_IDX_CROSS 1
`define TXC_IDX_BIAS_HIGH 2
`define TXC_IDX_MON_SEL 3
`define TXC_IDX_BIAS_THR 4
`define TXC_IDX_POWER_THR 5

`define TXC_REG_RESET 8'h00
`define TXC_READ_UNMAPPED 8'h00

`define TXC_BIT_LEG 7
`define TXC_BIT_MODE 6
`define TXC_BIT_DELAY 5
`define TXC_BIT_SLOW 4
`define TXC_BIT_MON_PD 6
`define TXC_BIT_MON_BIAS 5

`define TXC_STEP_X1 2'h0
`define TXC_STEP_X2 2'h1
`define TXC_STEP_X4 2'h2

`endif

/* tx_driver_control_pkg.sv */
// types shared by the transmit driver control bank and its register cells
// assumes the params header supplies all numeric constants
package tx_driver_control_pkg;

    typedef struct packed {
        logic leg_negative;
        logic single_ended;
        logic deemph_delayed;
        logic slow_edge;
        logic [3:0] strength;
    } shape_fields_t;

    typedef struct packed {
        logic direction;
        logic [6:0] magnitude;
    } cross_fields_t;

    typedef struct packed {
        logic rsv_7;
        logic pd_digital;
        logic bias_digital;
        logic [2:0] rsv_4_2;
        logic [1:0] bias_low;
    } monsel_fields_t;

    typedef struct packed {
        logic single_ended_leg_select;
        logic output_drive_config;
        logic deemph_delay_select;
        logic slow_edge_select;
        logic [3:0] deemph_strength;
        logic pos_leg_active;
        logic neg_leg_active;
        logic cross_point_direction;
        logic [6:0] cross_point_magnitude;
        logic [9:0] laser_bias_code;
        logic digital_pd_monitor_select;
        logic digital_bias_monitor_select;
        logic [7:0] bias_fault_threshold;
        logic [7:0] power_fault_threshold;
    } tx_drive_cfg_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic rd_valid;
        logic [7:0] rdata;
    } host_rsp_t;

    typedef struct packed {
        host_rsp_t rsp;
        logic bias_fault;
        logic power_fault;
        logic [1:0] apc_step_shift;
    } ctrl_state_t;

    typedef struct packed {
        logic [7:0] value;
    } cell_state_t;

endpackage

/* byte_reg_cell.sv */
// one byte-wide read/write control register, every bit stored as written
// assumes the write enable is already decoded for this register
`include "tx_driver_control_params.svh"
module byte_reg_cell #(
    parameter logic [7:0] RESET_VALUE = `TXC_REG_RESET
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] value
);
    tx_driver_control_pkg::cell_state_t state_q;
    tx_driver_control_pkg::cell_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.value = wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= '{value: RESET_VALUE};
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.value;

    AST_CELL_HOLDS: assert property (@(posedge mclk) disable iff (rst)
        !wr_en |=> value == $past(value))
        else $error("register byte changed without a write");
endmodule // byte_reg_cell

/* tx_driver_control_registers.sv */
// transmit driver control bank: six byte registers, field decode and monitor faults
// assumes the two-wire protocol engine presents decoded byte writes and reads
// How it works
// - in single-ended drive, output-control bit 7 picks negative leg, else positive
// - output-control bit 6 high selects single-ended drive, low selects differential
// - bit 5 picks delayed de-emphasis; bits 3:0 set de-emphasis strength
// - output-control bit 4 high selects slow edges, low normal edges
// - cross-point bit 7 gives shift direction, bits 6:0 its magnitude
// - ten-bit bias code: eight high bits one register, two low from register 16
// - bias code 0..1023, photodiode range 00/01/1X doubles step each time
// - monitor-select bit 6 high uses digital photodiode monitor, low analog
// - monitor-select bit 5 high uses digital bias monitor, low analog
// - with digital bias monitor, threshold byte sets bias fault level
// - with digital photodiode monitor, threshold byte sets power fault level
`include "tx_driver_control_params.svh"
module tx_driver_control_registers #(
    parameter int NUM_REGS = `TXC_NUM_REGS
) (
    input wire logic mclk,
    input wire logic rst,
    input tx_driver_control_pkg::host_req_t host_req,
    output tx_driver_control_pkg::host_rsp_t host_rsp,
    input wire logic [1:0] photodiode_range_code,
    input wire logic [7:0] bias_monitor_code,
    input wire logic [7:0] pd_monitor_code,
    output tx_driver_control_pkg::tx_drive_cfg_t drive_cfg,
    output logic bias_fault,
    output logic power_fault,
    output logic [1:0] apc_step_shift
);
    tx_driver_control_pkg::ctrl_state_t state_q;
    tx_driver_control_pkg::ctrl_state_t state_d;
    logic [7:0] reg_val [NUM_REGS];
    logic [NUM_REGS-1:0] wr_sel;
    logic [NUM_REGS-1:0] rd_sel;
    tx_driver_control_pkg::shape_fields_t shape;
    tx_driver_control_pkg::cross_fields_t cross_pt;
    tx_driver_control_pkg::monsel_fields_t monsel;
    logic [7:0] rd_mux;

    // one-hot register select from a host address, zero when unmapped
    function automatic logic [NUM_REGS-1:0] reg_onehot(input logic [7:0] addr);
        logic [NUM_REGS-1:0] sel;
        sel = '0;
        unique case (addr)
            `TXC_ADDR_SHAPE: sel[`TXC_IDX_SHAPE] = 1'b1;
            `TXC_ADDR_CROSS: sel[`TXC_IDX_CROSS] = 1'b1;
            `TXC_ADDR_BIAS_HIGH: sel[`TXC_IDX_BIAS_HIGH] = 1'b1;
            `TXC_ADDR_MON_SEL: sel[`TXC_IDX_MON_SEL] = 1'b1;
            `TXC_ADDR_BIAS_THR: sel[`TXC_IDX_BIAS_THR] = 1'b1;
            `TXC_ADDR_POWER_THR: sel[`TXC_IDX_POWER_THR] = 1'b1;
            default: sel = '0;
        endcase
        return sel;
    endfunction

    assign wr_sel = host_req.wr_en ? reg_onehot(host_req.addr) : '0;
    assign rd_sel = reg_onehot(host_req.addr);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_cell
            byte_reg_cell #(
                .RESET_VALUE(`TXC_REG_RESET)
            ) u_cell (
                .mclk(mclk),
                .rst(rst),
                .wr_en(wr_sel[gi]),
                .wdata(host_req.wdata),
                .value(reg_val[gi])
            );
        end
    endgenerate

    assign shape = reg_val[`TXC_IDX_SHAPE];
    assign cross_pt = reg_val[`TXC_IDX_CROSS];
    assign monsel = reg_val[`TXC_IDX_MON_SEL];

    // field fan-out straight from the register flops
    always_comb begin
        drive_cfg = '0;
        drive_cfg.single_ended_leg_select = shape.leg_negative;
        drive_cfg.output_drive_config = shape.single_ended;
        drive_cfg.deemph_delay_select = shape.deemph_delayed;
        drive_cfg.deemph_strength = shape.strength;
        drive_cfg.slow_edge_select = shape.slow_edge;
        drive_cfg.pos_leg_active = !shape.single_ended || !shape.leg_negative;
        drive_cfg.neg_leg_active = !shape.single_ended || shape.leg_negative;
        drive_cfg.cross_point_direction = cross_pt.direction;
        drive_cfg.cross_point_magnitude = cross_pt.magnitude;
        drive_cfg.laser_bias_code = {reg_val[`TXC_IDX_BIAS_HIGH], monsel.bias_low};
        drive_cfg.digital_pd_monitor_select = monsel.pd_digital;
        drive_cfg.digital_bias_monitor_select = monsel.bias_digital;
        drive_cfg.bias_fault_threshold = reg_val[`TXC_IDX_BIAS_THR];
        drive_cfg.power_fault_threshold = reg_val[`TXC_IDX_POWER_THR];
    end

    // read mux sees the value before a same-cycle write
    always_comb begin
        rd_mux = `TXC_READ_UNMAPPED;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (rd_sel[i]) begin
                rd_mux = reg_val[i];
            end
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.rsp.rd_valid = host_req.rd_en;
        if (host_req.rd_en) begin
            state_d.rsp.rdata = rd_mux;
        end
        // faults only meaningful with the internal digital monitors
        state_d.bias_fault = monsel.bias_digital
            && (bias_monitor_code >= reg_val[`TXC_IDX_BIAS_THR]);
        state_d.power_fault = monsel.pd_digital
            && (pd_monitor_code >= reg_val[`TXC_IDX_POWER_THR]);
        // step doubles per range code; 1x is the widest
        if (photodiode_range_code[1]) begin
            state_d.apc_step_shift = `TXC_STEP_X4;
        end else if (photodiode_range_code[0]) begin
            state_d.apc_step_shift = `TXC_STEP_X2;
        end else begin
            state_d.apc_step_shift = `TXC_STEP_X1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign host_rsp = state_q.rsp;
    assign bias_fault = state_q.bias_fault;
    assign power_fault = state_q.power_fault;
    assign apc_step_shift = state_q.apc_step_shift;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_shape_write;
        host_req.wr_en && host_req.addr == `TXC_ADDR_SHAPE;
    endsequence

    sequence s_monsel_write;
        host_req.wr_en && host_req.addr == `TXC_ADDR_MON_SEL;
    endsequence

    sequence s_write_then_read;
        host_req.wr_en && reg_onehot(host_req.addr) != '0 ##1
        host_req.rd_en && !host_req.wr_en && host_req.addr == $past(host_req.addr);
    endsequence

    AST_LEG_SELECT: assert property (
        s_shape_write |=> drive_cfg.output_drive_config ->
            (drive_cfg.neg_leg_active == $past(host_req.wdata[`TXC_BIT_LEG])
            && drive_cfg.pos_leg_active != $past(host_req.wdata[`TXC_BIT_LEG])))
        else $error("single-ended leg does not follow select bit");

    AST_DIFF_MODE: assert property (
        s_shape_write ##0 !host_req.wdata[`TXC_BIT_MODE]
        |=> !drive_cfg.output_drive_config && drive_cfg.pos_leg_active && drive_cfg.neg_leg_active)
        else $error("differential mode must drive both legs");

    AST_DEEMPH_WRITE: assert property (
        s_shape_write |=> drive_cfg.deemph_delay_select == $past(host_req.wdata[`TXC_BIT_DELAY])
            && drive_cfg.deemph_strength == $past(host_req.wdata[3:0]))
        else $error("de-emphasis fields not taken from write");

    AST_SLOW_WRITE: assert property (
        s_shape_write |=> drive_cfg.slow_edge_select == $past(host_req.wdata[`TXC_BIT_SLOW]))
        else $error("edge speed not taken from write");

    AST_CROSS_WRITE: assert property (
        host_req.wr_en && host_req.addr == `TXC_ADDR_CROSS
        |=> {drive_cfg.cross_point_direction, drive_cfg.cross_point_magnitude} == $past(host_req.wdata))
        else $error("cross-point fields not taken from write");

    AST_BIAS_HIGH: assert property (
        host_req.wr_en && host_req.addr == `TXC_ADDR_BIAS_HIGH
        |=> drive_cfg.laser_bias_code[9:2] == $past(host_req.wdata)
            && $stable(drive_cfg.laser_bias_code[1:0]))
        else $error("bias code high byte wrong");

    AST_BIAS_LOW: assert property (
        s_monsel_write |=> drive_cfg.laser_bias_code[1:0] == $past(host_req.wdata[1:0])
            && $stable(drive_cfg.laser_bias_code[9:2]))
        else $error("bias code low bits wrong");

    AST_APC_STEP: assert property (
        photodiode_range_code[1] |=> apc_step_shift == `TXC_STEP_X4)
        else $error("range 1x must give largest step");

    AST_APC_STEP_MID: assert property (
        photodiode_range_code == 2'h1 |=> apc_step_shift == `TXC_STEP_X2)
        else $error("range 01 must give doubled step");

    AST_PD_MON_SEL: assert property (
        s_monsel_write |=> drive_cfg.digital_pd_monitor_select == $past(host_req.wdata[`TXC_BIT_MON_PD]))
        else $error("photodiode monitor select not taken");

    AST_BIAS_MON_SEL: assert property (
        s_monsel_write |=> drive_cfg.digital_bias_monitor_select == $past(host_req.wdata[`TXC_BIT_MON_BIAS]))
        else $error("bias monitor select not taken");

    AST_BIAS_FAULT: assert property (
        ##1 bias_fault == ($past(drive_cfg.digital_bias_monitor_select)
            && $past(bias_monitor_code) >= $past(drive_cfg.bias_fault_threshold)))
        else $error("bias fault does not match threshold");

    AST_POWER_FAULT: assert property (
        !drive_cfg.digital_pd_monitor_select [*2] |-> !power_fault)
        else $error("power fault raised with analog monitor");

    AST_POWER_FAULT_SET: assert property (
        drive_cfg.digital_pd_monitor_select && pd_monitor_code >= drive_cfg.power_fault_threshold
        |=> power_fault)
        else $error("power fault missed at threshold");

    AST_READBACK: assert property (
        s_write_then_read |=> host_rsp.rd_valid && host_rsp.rdata == $past(host_req.wdata, 2))
        else $error("register does not read back as written");

    AST_UNMAPPED_READ: assert property (
        host_req.rd_en && reg_onehot(host_req.addr) == '0
        |=> host_rsp.rd_valid && host_rsp.rdata == `TXC_READ_UNMAPPED)
        else $error("unmapped read not zero");
endmodule // tx_driver_control_registers

/* tx_host_model.sv */
// host model: byte write and read strobes toward the control bank
// assumes each task is entered at a falling mclk edge
module tx_host_model (
    input wire logic mclk,
    output tx_driver_control_pkg::host_req_t req,
    input tx_driver_control_pkg::host_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.rd_en = 1'b0;
        req.wr_en = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge mclk);
    endtask
    // answer taken one edge after the request
    task automatic rd(input logic [7:0] a, output logic ok, output logic [7:0] d);
        req.wr_en = 1'b0;
        req.rd_en = 1'b1;
        req.addr = a;
        @(negedge mclk);
        ok = rsp.rd_valid;
        d = rsp.rdata;
    endtask
    // write and read of one register in the same cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic ok, output logic [7:0] q);
        req.wr_en = 1'b1;
        req.rd_en = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge mclk);
        ok = rsp.rd_valid;
        q = rsp.rdata;
    endtask
    // strobes drop low; address and data lines show the inverse of their last value
    task automatic idle();
        req.wr_en = 1'b0;
        req.rd_en = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
        @(negedge mclk);
    endtask
endmodule // tx_host_model

/* tx_driver_control_registers_tb.sv */
// self-checking bench for the transmit driver control bank
// assumes the host model drives the byte port and the header gives addresses
`include "tx_driver_control_params.svh"
module tx_driver_control_registers_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] pd_rng = 2'h0;
    logic [7:0] bias_mon = 8'h00;
    logic [7:0] pd_mon = 8'h00;
    tx_driver_control_pkg::host_req_t req;
    tx_driver_control_pkg::host_rsp_t rsp;
    tx_driver_control_pkg::tx_drive_cfg_t cfg;
    logic bias_flt;
    logic pwr_flt;
    logic [1:0] step;
    logic [5:0][7:0] shadow = '0;
    logic [31:0] seed = 32'h52;
    int mismatches = 0;
    int checked = 0;
    logic ok;
    logic [7:0] rv;
    logic [7:0] thr_b;
    logic [7:0] thr_p;
    logic [7:0] sel [4] = '{8'h60, 8'h20, 8'h40, 8'h9f};
    logic [7:0] bad_addr [4] = '{8'h0c, 8'h13, 8'hff, 8'h00};

    always #25 mclk = ~mclk;

    tx_host_model host (.mclk(mclk), .req(req), .rsp(rsp));
    tx_driver_control_registers dut (.mclk(mclk), .rst(rst), .host_req(req), .host_rsp(rsp),
        .photodiode_range_code(pd_rng), .bias_monitor_code(bias_mon), .pd_monitor_code(pd_mon),
        .drive_cfg(cfg), .bias_fault(bias_flt), .power_fault(pwr_flt), .apc_step_shift(step));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic tx_driver_control_pkg::tx_drive_cfg_t exp_cfg(input logic [5:0][7:0] r);
        tx_driver_control_pkg::tx_drive_cfg_t c;
        c.single_ended_leg_select = r[0][7];
        c.output_drive_config = r[0][6];
        c.deemph_delay_select = r[0][5];
        c.slow_edge_select = r[0][4];
        c.deemph_strength = r[0][3:0];
        c.pos_leg_active = !r[0][6] || !r[0][7];
        c.neg_leg_active = !r[0][6] || r[0][7];
        c.cross_point_direction = r[1][7];
        c.cross_point_magnitude = r[1][6:0];
        c.laser_bias_code = {r[2], r[3][1:0]};
        c.digital_pd_monitor_select = r[3][6];
        c.digital_bias_monitor_select = r[3][5];
        c.bias_fault_threshold = r[4];
        c.power_fault_threshold = r[5];
        return c;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // write one byte, compare all fields, read it straight back
    task automatic put(input int idx, input logic [7:0] d);
        host.wr(8'(`TXC_ADDR_SHAPE + idx), d);
        shadow[idx] = d;
        check(cfg, exp_cfg(shadow), "fields");
        host.rd(8'(`TXC_ADDR_SHAPE + idx), ok, rv);
        check({ok, rv}, {1'b1, d}, "readback");
    endtask

    initial begin
        #(20000 * 50);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        check(cfg, exp_cfg(shadow), "reset fields");
        check({bias_flt, pwr_flt, step}, 4'h0, "reset faults");
        for (int i = 0; i < 6; i++) begin
            host.rd(8'(`TXC_ADDR_SHAPE + i), ok, rv);
            check({ok, rv}, {1'b1, 8'h00}, "reset read");
        end
        host.idle();
        check(rsp.rd_valid, 1'b0, "valid pulse");
        $display("reset test done");
        foreach (sel[i]) begin
            put(0, {sel[i][7:6], ~sel[i][7:6], i[1:0], 2'h3});
            put(1, {i[0], 7'h7f});
            put(1, {i[1], 7'h00});
        end
        put(2, 8'hff);
        put(3, 8'h03);
        put(2, 8'h00);
        $display("corner test done");
        for (int n = 0; n < 200; n++) begin
            put(int'(rnd() % 6), 8'(rnd()));
            if (rnd() & 32'h1) begin
                host.idle();
            end
        end
        $display("random test done");
        foreach (bad_addr[i]) begin
            host.wr(bad_addr[i], 8'h5a);
            check(cfg, exp_cfg(shadow), "unmapped write");
            host.rd(bad_addr[i], ok, rv);
            check({ok, rv}, {1'b1, 8'h00}, "unmapped read");
        end
        host.wr_rd(`TXC_ADDR_CROSS, 8'ha5, ok, rv);
        check({ok, rv}, {1'b1, shadow[1]}, "same-cycle read");
        shadow[1] = 8'ha5;
        check(cfg, exp_cfg(shadow), "same-cycle write");
        $display("unmapped test done");
        foreach (sel[i]) begin
            thr_b = 8'(rnd());
            thr_p = (i == 1) ? 8'h00 : 8'(rnd());
            put(3, sel[i]);
            put(4, thr_b);
            put(5, thr_p);
            host.idle();
            for (int n = 0; n < 40; n++) begin
                bias_mon = (n % 4 == 0) ? thr_b : (n % 4 == 1) ? thr_b - 8'h01 : 8'(rnd());
                pd_mon = (n % 4 == 2) ? thr_p : (n % 4 == 3) ? thr_p - 8'h01 : 8'(rnd());
                pd_rng = 2'(rnd());
                @(negedge mclk);
                check(bias_flt, sel[i][5] && bias_mon >= thr_b, "bias fault");
                check(pwr_flt, sel[i][6] && pd_mon >= thr_p, "power fault");
                check(step, pd_rng[1] ? 2'h2 : pd_rng, "step");
            end
        end
        $display("fault test done");
        end_of_test();
    end
endmodule // tx_driver_control_registers_tb
